// ### isp_consts.vh
// Constants for the I2C slave register port: addresses, byte layout, reset values.
// Assumes it is included by bare name from the design files of this block.
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH

// 7-bit slave addresses chosen by the strap pin
`define ISP_ADDR_STRAP_LOW  7'h40
`define ISP_ADDR_STRAP_HIGH 7'h41

// Bits per byte on the wire, and the last bit index of a byte
`define ISP_BYTE_BITS       4'h8
`define ISP_MSB_POS         3'h7

// Position of the read/write bit inside the address byte
`define ISP_RW_POS          0
`define ISP_RW_READ         1'h1

// Reset values
`define ISP_PTR_RESET       8'h00
`define ISP_BYTE_RESET      8'h00
`define ISP_LINE_IDLE       1'h1

`endif

// ### isp_pin_sync.v
// Three-stage pin synchroniser with agreement filter for the I2C slave port.
// Assumes the input is asynchronous to clk_in; output follows once stages two and three agree.
`timescale 1ns/1ps
`include "isp_consts.vh"

module isp_pin_sync #(
  parameter INIT = 1'b1                 // Level shown during and after reset
) (
  input  wire clk_in,                   // Block clock
  input  wire rstn_in,                  // Synchronous reset, active low
  input  wire pin_in,                   // Raw asynchronous level
  output reg  level_out                 // Filtered level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // First stage is read only by the second; the filter looks at stages two and three
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      stage1    <= INIT;
      stage2    <= INIT;
      stage3    <= INIT;
      level_out <= INIT;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level_out <= stage3;            // Glitch shorter than a cycle never reaches here
    end
  end

endmodule // isp_pin_sync

// ### isp_slave_port.v
// I2C slave port giving a bus master byte access to the device's register space.
// Assumes SCL, SDA and the address strap come from pins; the register file answers
// RD_DATA_IN combinationally for the address on REG_ADDR_OUT.
`timescale 1ns/1ps
`include "isp_consts.vh"

// What this block does
// - With the strap low the port answers 7-bit address 0x40 (0x80 write, 0x81 read).
// - With the strap at the I/O supply the port answers address 0x41 (0x82 write, 0x83 read).
// - Every byte on the wire is eight bits, most significant bit first.
// - The receiver of each byte returns an acknowledge in the ninth clock period.
// - SDA falling while SCL is high is a start; SDA rising while SCL is high is a stop.
// - The sender changes data bits only while SCL is low.
// - The port acknowledges by holding SDA low for the whole acknowledge clock period.
// - Transfers of any length between start and stop are accepted.
// - A write's first byte sets the pointer; each later byte is stored there and steps it.
// - Every written data byte is acknowledged.
// - In a read the port sends from the pointer onward, one register per acknowledged byte.
module isp_slave_port (
  input  wire       CLK_IN,             // Block clock, 250 MHz
  input  wire       RSTN_IN,            // Synchronous reset, active low
  input  wire       SCL_IN,             // Bus clock pin level
  input  wire       SDA_IN,             // Bus data pin level
  output reg        SDA_OUT,            // Data drive value, always low
  output reg        SDA_OE_OUT,         // High while the port pulls SDA low
  input  wire       ADDR_SEL_IN,        // Address strap: low or io_supply_level
  output reg  [7:0] REG_ADDR_OUT,       // Register pointer
  output reg  [7:0] WR_DATA_OUT,        // Byte to write
  output reg        WR_STB_OUT,         // One-cycle write strobe
  input  wire [7:0] RD_DATA_IN,         // Byte at REG_ADDR_OUT
  output reg        RD_STB_OUT,         // One-cycle pulse when a read byte is taken
  output reg        BUSY_OUT            // High while addressed between start and stop
);

  // One-hot protocol states
  localparam [5:0] ST_IDLE   = 6'h01;
  localparam [5:0] ST_RECV   = 6'h02;
  localparam [5:0] ST_ACK    = 6'h04;
  localparam [5:0] ST_SEND   = 6'h08;
  localparam [5:0] ST_MACK   = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;

  // Meaning of the byte being received
  localparam [1:0] KIND_ADDR = 2'h0;
  localparam [1:0] KIND_PTR  = 2'h1;
  localparam [1:0] KIND_DATA = 2'h2;

  wire       scl;
  wire       sda;
  wire       strap;
  reg        scl_prev;
  reg        sda_prev;
  reg        strap_hold;
  reg  [5:0] state;
  reg  [1:0] kind;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg        read_mode;
  reg        master_ack;

  // Pin synchronisers; SCL from the master is sampled, not used as a clock
  isp_pin_sync #(.INIT(`ISP_LINE_IDLE)) u_sync_scl (
    .clk_in    (CLK_IN),
    .rstn_in   (RSTN_IN),
    .pin_in    (SCL_IN),
    .level_out (scl)
  );

  isp_pin_sync #(.INIT(`ISP_LINE_IDLE)) u_sync_sda (
    .clk_in    (CLK_IN),
    .rstn_in   (RSTN_IN),
    .pin_in    (SDA_IN),
    .level_out (sda)
  );

  isp_pin_sync #(.INIT(1'b0)) u_sync_strap (
    .clk_in    (CLK_IN),
    .rstn_in   (RSTN_IN),
    .pin_in    (ADDR_SEL_IN),
    .level_out (strap)
  );

  // Bus events from the filtered levels and their previous values
  wire scl_rise   = scl & ~scl_prev;
  wire scl_fall   = ~scl & scl_prev;
  wire bus_start  = scl & scl_prev & sda_prev & ~sda;
  wire bus_stop   = scl & scl_prev & ~sda_prev & sda;
  wire byte_done  = (bit_cnt == `ISP_BYTE_BITS);
  wire [6:0] own_addr = strap_hold ? `ISP_ADDR_STRAP_HIGH
                                   : `ISP_ADDR_STRAP_LOW;
  wire addr_match = (shift[7:1] == own_addr);

  // Previous levels for edge finding
  always @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      scl_prev <= `ISP_LINE_IDLE;
      sda_prev <= `ISP_LINE_IDLE;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  // Strap is caught at each start, so a slow strap settles before it matters
  always @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
      strap_hold <= 1'b0;
    else if (bus_start)
      strap_hold <= strap;
  end

  // Pointer steps once after each write strobe or read byte
  always @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
      REG_ADDR_OUT <= `ISP_PTR_RESET;
    else if (state == ST_RECV && scl_fall && byte_done && kind == KIND_PTR)
      REG_ADDR_OUT <= shift;
    else if (WR_STB_OUT || RD_STB_OUT)
      REG_ADDR_OUT <= REG_ADDR_OUT + 8'h01;
  end

  // Protocol engine: sample on SCL rise, drive SDA after SCL fall
  always @(posedge CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      state       <= ST_IDLE;
      kind        <= KIND_ADDR;
      bit_cnt     <= 4'h0;
      shift       <= `ISP_BYTE_RESET;
      read_mode   <= 1'b0;
      master_ack  <= 1'b0;
      SDA_OUT     <= 1'b0;
      SDA_OE_OUT  <= 1'b0;
      WR_DATA_OUT <= `ISP_BYTE_RESET;
      WR_STB_OUT  <= 1'b0;
      RD_STB_OUT  <= 1'b0;
      BUSY_OUT    <= 1'b0;
    end
    else
    begin
      WR_STB_OUT <= 1'b0;
      RD_STB_OUT <= 1'b0;
      SDA_OUT    <= 1'b0;                                         // Open drain: only pull low
      if (bus_start)
      begin
        // A start, repeated or not, always restarts address reception
        state      <= ST_RECV;
        kind       <= KIND_ADDR;
        bit_cnt    <= 4'h0;
        SDA_OE_OUT <= 1'b0;
        BUSY_OUT   <= 1'b0;
      end
      else if (bus_stop)
      begin
        state      <= ST_IDLE;
        SDA_OE_OUT <= 1'b0;
        BUSY_OUT   <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE, ST_IGNORE:
          begin
            SDA_OE_OUT <= 1'b0;
          end
          ST_RECV:
          begin
            if (scl_rise && !byte_done)
            begin
              shift   <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && byte_done)
            begin
              // Byte complete: decide whether to acknowledge it
              bit_cnt <= 4'h0;
              if (kind == KIND_ADDR)
              begin
                if (addr_match)
                begin
                  read_mode  <= (shift[`ISP_RW_POS] == `ISP_RW_READ);
                  SDA_OE_OUT <= 1'b1;
                  BUSY_OUT   <= 1'b1;
                  state      <= ST_ACK;
                end
                else
                  state <= ST_IGNORE;
              end
              else
              begin
                if (kind == KIND_DATA)
                begin
                  WR_DATA_OUT <= shift;
                  WR_STB_OUT  <= 1'b1;
                end
                SDA_OE_OUT <= 1'b1;
                state      <= ST_ACK;
              end
            end
          end
          ST_ACK:
          begin
            // Acknowledge held low through the ninth clock; on its fall released in a write, or set to the first data bit in a read
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (read_mode)
              begin
                shift      <= RD_DATA_IN;
                RD_STB_OUT <= 1'b1;
                SDA_OE_OUT <= ~RD_DATA_IN[`ISP_MSB_POS];
                state      <= ST_SEND;
              end
              else
              begin
                SDA_OE_OUT <= 1'b0;
                kind       <= (kind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
                state      <= ST_RECV;
              end
            end
          end
          ST_SEND:
          begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 4'h1;
            else if (scl_fall)
            begin
              if (byte_done)
              begin
                SDA_OE_OUT <= 1'b0;                               // Master owns the ninth bit
                state      <= ST_MACK;
              end
              else
              begin
                shift      <= {shift[6:0], 1'b0};
                SDA_OE_OUT <= ~shift[6];
              end
            end
          end
          ST_MACK:
          begin
            if (scl_rise)
              master_ack <= ~sda;
            else if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (master_ack)
              begin
                shift      <= RD_DATA_IN;
                RD_STB_OUT <= 1'b1;
                SDA_OE_OUT <= ~RD_DATA_IN[`ISP_MSB_POS];
                state      <= ST_SEND;
              end
              else
                state <= ST_IGNORE;                               // Wait for the stop
            end
          end
          default:
          begin
            state      <= ST_IDLE;
            SDA_OE_OUT <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // isp_slave_port

// ### isp_slave_port_sva.sv
// Checker bound to the ports of the I2C slave port.
// Assumes bus clock halves of at least eight block clocks.
`timescale 1ns/1ps
module isp_slave_port_sva (
  input wire       CLK_IN,       // Clock
  input wire       RSTN_IN,      // Reset
  input wire       SCL_IN,       // Bus clock
  input wire       SDA_IN,       // Bus data
  input wire       SDA_OE_OUT,   // Data pull
  input wire [7:0] REG_ADDR_OUT, // Pointer
  input wire       WR_STB_OUT,   // Write strobe
  input wire [7:0] RD_DATA_IN,   // Read byte
  input wire       RD_STB_OUT,   // Read strobe
  input wire       BUSY_OUT      // Addressed
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // The pin filter delays the drive, so a change trails a low bus clock
  a_oe_clk_low: assert property ($changed(SDA_OE_OUT) |-> !$past(SCL_IN, 4))
    else $error("drive moved, clock high");
  a_cond_idle: assert property (SCL_IN && $changed(SDA_IN) |-> ##[1:8] !BUSY_OUT)
    else $error("start or stop missed");
  a_oe_busy: assert property (SDA_OE_OUT |-> BUSY_OUT) else $error("drive when idle");
  a_wr_ack: assert property (WR_STB_OUT |-> SDA_OE_OUT) else $error("write not acked");
  a_wr_step: assert property (WR_STB_OUT |=> REG_ADDR_OUT == $past(REG_ADDR_OUT) + 8'h01)
    else $error("no step on write");
  a_rd_step: assert property (RD_STB_OUT |=> REG_ADDR_OUT == $past(REG_ADDR_OUT) + 8'h01)
    else $error("no step on read");
  a_rd_msb: assert property (RD_STB_OUT |-> SDA_OE_OUT == !RD_DATA_IN[7])
    else $error("first bit not msb");
  a_stb_one: assert property (WR_STB_OUT || RD_STB_OUT |=> !WR_STB_OUT && !RD_STB_OUT)
    else $error("strobe too long");
endmodule // isp_slave_port_sva
bind isp_slave_port isp_slave_port_sva isp_slave_port_sva_inst (.CLK_IN(CLK_IN),
  .RSTN_IN(RSTN_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OE_OUT(SDA_OE_OUT),
  .REG_ADDR_OUT(REG_ADDR_OUT), .WR_STB_OUT(WR_STB_OUT), .RD_DATA_IN(RD_DATA_IN),
  .RD_STB_OUT(RD_STB_OUT), .BUSY_OUT(BUSY_OUT));

// ### isp_host_model.sv
// Bus master model: drives SCL and pulls SDA, timed in block clocks.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ps
module isp_host_model (
  input  wire clk_in,            // Time base
  input  wire sda_in,            // Resolved data line
  output reg  scl_out = 1'b1,    // Bus clock, idles high
  output reg  sda_low_out = 1'b0 // High while pulling data low
);
  // Wait n cycles, then set clock and data pull on one edge
  task st(input c, input d, input integer n);
    repeat (n) @(posedge clk_in);
    scl_out <= c;
    sda_low_out <= d;
  endtask
  // Start, also repeated: data falls with the clock high
  task start;
    st(scl_out, 1'b0, 4);
    st(1'b1, 1'b0, 4);
    st(1'b1, 1'b1, 8);
    st(1'b0, 1'b1, 8);
  endtask
  // Stop: data rises with the clock high, freeing the bus
  task stop;
    st(1'b0, 1'b1, 4);
    st(1'b1, 1'b1, 4);
    st(1'b1, 1'b0, 8);
    st(1'b1, 1'b0, 8);
  endtask
  // Data moves mid low phase, so no edge can pose as start or stop
  task bitx(input b, output r);
    st(1'b0, ~b, 4);
    st(1'b1, ~b, 4);
    repeat (8) @(posedge clk_in);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  // Byte MSB first, then the ninth bit; a 1 there frees the line
  task xfer(input [7:0] d, input last, output [7:0] q, output ack);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
      bitx(d[i], q[i]);
    bitx(last, ack);
  endtask
endmodule // isp_host_model

// ### tb_isp_slave_port.sv
// Self-checking bench for the I2C slave port with a host master model.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module tb_isp_slave_port;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        addr_sel = 1'b0;
  wire       scl, m_low, sda_oe, sda_drv, wr_stb, rd_stb, busy;
  wire [7:0] reg_addr, wr_data;
  reg  [7:0] mem [0:255];
  reg  [7:0] q;
  reg        ack;
  integer    n_fail = 0;
  integer    checked = 0;
  integer    n_rd = 0;
  // Open drain with pull-up; the port's drive value is used, so a wrong level shows
  wire       sda = ~m_low & (sda_oe ? sda_drv : 1'b1);
  // Block clock at 250 MHz
  initial forever #2 clk = ~clk;
  // Register file: read at the pointer, written on the strobe
  always @(posedge clk)
    if (wr_stb)
      mem[reg_addr] <= wr_data;
  // Count bytes the port takes for sending
  always @(posedge clk)
    if (rd_stb)
      n_rd <= n_rd + 1;
  isp_slave_port isp_slave_port_inst (.CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_drv), .SDA_OE_OUT(sda_oe), .ADDR_SEL_IN(addr_sel),
    .REG_ADDR_OUT(reg_addr), .WR_DATA_OUT(wr_data), .WR_STB_OUT(wr_stb),
    .RD_DATA_IN(mem[reg_addr]), .RD_STB_OUT(rd_stb), .BUSY_OUT(busy));
  isp_host_model isp_host_model_inst (.clk_in(clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(m_low));
  // Compare one result and count it
  task chk(input [63:0] what, input [23:0] exp, input [23:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, got);
    end
  endtask
  // A byte and its ninth bit as seen on the line
  task xb(input [7:0] d, input last, input [8:0] exp);
    isp_host_model_inst.xfer(d, last, q, ack);
    chk("byte", {15'h0000, exp}, {15'h0000, q, ack});
  endtask
  // A written byte that must be acknowledged
  task wb(input [7:0] d);
    xb(d, 1'b1, {d, 1'b0});
  endtask
  // Both strap levels against both addresses; only a match answers
  task t_addr;
    integer s;
    for (s = 0; s < 4; s = s + 1)
    begin
      addr_sel <= s[1];
      isp_host_model_inst.start;
      xb({6'h20, s[0], 1'b0}, 1'b1, {6'h20, s[0], 1'b0, s[1] != s[0]});
      chk("busy", {23'h000000, s[1] == s[0]}, {23'h000000, busy});
      if (s[1] != s[0])
        xb(8'h00, 1'b1, {8'h00, 1'b1});
      isp_host_model_inst.stop;
    end
    $display("t_addr done");
  endtask
  // Write across the pointer wrap with the strap left high
  task t_write;
    isp_host_model_inst.start;
    wb(8'h82);
    wb(8'hfe);
    wb(8'h3c);
    wb(8'hb2);
    wb(8'h4d);
    isp_host_model_inst.stop;
    chk("regs", 24'h3cb24d, {mem[8'hfe], mem[8'hff], mem[8'h00]});
    $display("t_write done");
  endtask
  // Pointer write, repeated start, three reads ending in not-ack
  task t_read;
    isp_host_model_inst.start;
    wb(8'h82);
    wb(8'hfe);
    isp_host_model_inst.start;
    wb(8'h83);
    xb(8'hff, 1'b0, {8'h3c, 1'b0});
    xb(8'hff, 1'b0, {8'hb2, 1'b0});
    xb(8'hff, 1'b1, {8'h4d, 1'b1});
    isp_host_model_inst.stop;
    chk("pointer", 24'h000001, {16'h0000, reg_addr});
    chk("reads", 24'h000003, n_rd[23:0]);
    $display("t_read done");
  endtask
  // Counts, verdict and end of run; a timeout arrives with bad set
  task test_done(input bad);
    n_fail = n_fail + bad;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset, let the pin filters settle, then run the scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    t_addr;
    t_write;
    t_read;
    test_done(1'b0);
  end
  // Watchdog: the run needs about 3000 cycles, so this leaves wide margin
  initial #60000 test_done(1'b1);
endmodule // tb_isp_slave_port
